// File: rtl/arsr_fifo.sv
// Output word FIFO with registered read data
`timescale 1ns/1ns
module arsr_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 16
) (
  // Clock and control
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  // Data path
  arsr_fifo_if.fifo bus
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      cnt_r;
  logic [WIDTH-1:0] out_data_r;
  logic             out_valid_r;
  logic             push;
  logic             load;

  // Full is honest: the source stalls once the memory is full
  assign bus.wready = (cnt_r != (AW+1)'(DEPTH));
  assign push       = bus.wvalid && bus.wready;
  assign load       = (cnt_r != '0) && (!out_valid_r || bus.rready);
  assign bus.rvalid = out_valid_r;
  assign bus.rdata  = out_data_r;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_r] <= bus.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (load) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end else if (ce) begin
      if (load) begin
        out_valid_r <= 1'b1;
        out_data_r  <= mem[rd_ptr_r];
      end else if (bus.rready) begin
        out_valid_r <= 1'b0;
      end
    end
  end
endmodule : arsr_fifo

// File: rtl/arsr_fifo_if.sv
// Valid/ready carrier between the slot sequencer and the output FIFO
`timescale 1ns/1ns
interface arsr_fifo_if #(parameter int WIDTH = 28);
  logic [WIDTH-1:0] wdata;
  logic             wvalid;
  logic             wready;
  logic [WIDTH-1:0] rdata;
  logic             rvalid;
  logic             rready;
  modport fifo (input wdata, wvalid, rready, output wready, rdata, rvalid);
  modport user (output wdata, wvalid, rready, input wready, rdata, rvalid);
endinterface : arsr_fifo_if

// File: rtl/arsr_pkg.sv
// Types shared by the audio route select bank
package arsr_pkg;
  typedef logic [3:0] arsr_src_type;
  typedef logic [2:0] arsr_chan_type;
  typedef enum logic [1:0] {
    ARSR_IDLE  = 2'b00,
    ARSR_PIN_A = 2'b01,
    ARSR_PIN_B = 2'b10
  } arsr_state_type;
endpackage : arsr_pkg

// File: rtl/arsr_regs.svh
// Register offsets, field positions and reset values for the audio route select bank
`ifndef ARSR_REGS_SVH
`define ARSR_REGS_SVH
`define ARSR_OFS_START      8'h17
`define ARSR_OFS_SRC_LO     8'h18
`define ARSR_OFS_SRC_HI     8'h19
`define ARSR_RST_START      8'h04
`define ARSR_RST_SRC_LO     8'h10
`define ARSR_RST_SRC_HI     8'h32
`define ARSR_START_A_LSB    0
`define ARSR_START_B_LSB    2
`define ARSR_START_RSV_LSB  4
`define ARSR_SRC_LO_LSB     0
`define ARSR_SRC_HI_LSB     4
`define ARSR_SLOTS_PAIR     3'h1
`define ARSR_SLOTS_TDM      3'h3
`endif

// File: rtl/arsr_top.sv
// Audio route select register bank with ADC serial slot sequencer and converter source muxes
`timescale 1ns/1ns
`include "arsr_regs.svh"
module arsr_top #(
  parameter int DW    = 24,
  parameter int DEPTH = 16
) (
  // Clock, reset, enable
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   ce,
  // Host control port
  input  wire logic [7:0]             reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata,
  output logic                        reg_rvalid,
  // Converter source inputs and outputs
  input  wire logic                   sample_strobe,
  input  wire logic [DW-1:0]          adc_data [4],
  input  wire logic [DW-1:0]          serial_in_data [8],
  output logic      [DW-1:0]          conv_data [4],
  output logic      [3:0]             conv_valid,
  // ADC serial output framing
  input  wire logic                   serial_format_select,
  input  wire logic                   frame_strobe,
  input  wire logic [DW-1:0]          slot_data [8],
  output logic                        frame_busy,
  // Serial slot stream
  output logic                        ser_valid,
  input  wire logic                   ser_ready,
  output logic                        ser_pin_b,
  output arsr_pkg::arsr_chan_type     ser_chan,
  output logic      [DW-1:0]          ser_data
);
  import arsr_pkg::*;

  localparam int FW = DW + 4;

  logic [7:0]      start_r;
  logic [7:0]      src_lo_r;
  logic [7:0]      src_hi_r;
  arsr_state_type  state_r;
  logic [2:0]      cnt_r;
  logic [DW-1:0]   snap_r [8];
  arsr_chan_type   chan;
  logic [2:0]      last_cnt;
  logic            push;
  arsr_src_type    src [4];

  arsr_fifo_if #(.WIDTH(FW)) fq ();

  function automatic arsr_chan_type start_chan(input logic [1:0] code);
    return {code, 1'b0};
  endfunction : start_chan

  function automatic logic src_ok(input arsr_src_type code);
    return code[3] || code[2];
  endfunction : src_ok

  ////////////////////////////////////////////////////////////////////////////
  // Register bank; reserved bits are stored as written
  always_ff @(posedge clk) begin
    if (srst) begin
      start_r  <= `ARSR_RST_START;
      src_lo_r <= `ARSR_RST_SRC_LO;
      src_hi_r <= `ARSR_RST_SRC_HI;
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        `ARSR_OFS_START:  start_r  <= reg_wdata;
        `ARSR_OFS_SRC_LO: src_lo_r <= reg_wdata;
        `ARSR_OFS_SRC_HI: src_hi_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Unmapped offsets read as zero
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          `ARSR_OFS_START:  reg_rdata <= start_r;
          `ARSR_OFS_SRC_LO: reg_rdata <= src_lo_r;
          `ARSR_OFS_SRC_HI: reg_rdata <= src_hi_r;
          default:          reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter source muxes
  assign src[0] = src_lo_r[`ARSR_SRC_LO_LSB +: 4];
  assign src[1] = src_lo_r[`ARSR_SRC_HI_LSB +: 4];
  assign src[2] = src_hi_r[`ARSR_SRC_LO_LSB +: 4];
  assign src[3] = src_hi_r[`ARSR_SRC_HI_LSB +: 4];

  for (genvar k = 0; k < 4; k++) begin : g_conv
    // Reserved codes drive silence rather than a stale sample
    always_ff @(posedge clk) begin
      if (srst) begin
        conv_data[k]  <= '0;
        conv_valid[k] <= 1'b0;
      end else if (ce && sample_strobe) begin
        conv_valid[k] <= src_ok(src[k]);
        if (src[k][3]) begin
          conv_data[k] <= serial_in_data[src[k][2:0]];
        end else if (src[k][2]) begin
          conv_data[k] <= adc_data[src[k][1:0]];
        end else begin
          conv_data[k] <= '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot sequencer: pin A then pin B, each from its start channel upward
  assign last_cnt = serial_format_select ? `ARSR_SLOTS_TDM : `ARSR_SLOTS_PAIR;
  assign chan = (state_r == ARSR_PIN_B)
              ? start_chan(start_r[`ARSR_START_B_LSB +: 2]) + cnt_r
              : start_chan(start_r[`ARSR_START_A_LSB +: 2]) + cnt_r;
  assign fq.wvalid = (state_r != ARSR_IDLE);
  assign fq.wdata  = {(state_r == ARSR_PIN_B), chan, snap_r[chan]};
  assign push      = ce && fq.wvalid && fq.wready;
  assign frame_busy = (state_r != ARSR_IDLE);

  // A frame strobe while busy is ignored; a full FIFO stalls the walk
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ARSR_IDLE;
      cnt_r   <= 3'h0;
    end else if (ce) begin
      unique case (state_r)
        ARSR_IDLE: begin
          if (frame_strobe) begin
            state_r <= ARSR_PIN_A;
            cnt_r   <= 3'h0;
          end
        end
        ARSR_PIN_A, ARSR_PIN_B: begin
          if (push) begin
            if (cnt_r == last_cnt) begin
              cnt_r   <= 3'h0;
              state_r <= (state_r == ARSR_PIN_A) ? ARSR_PIN_B : ARSR_IDLE;
            end else begin
              cnt_r <= cnt_r + 3'h1;
            end
          end
        end
        default: state_r <= ARSR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (ce && frame_strobe && state_r == ARSR_IDLE) begin
      snap_r <= slot_data;
    end
  end

  arsr_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .bus  (fq.fifo)
  );

  assign fq.rready = ser_ready && ce;
  assign ser_valid = fq.rvalid;
  assign ser_pin_b = fq.rdata[FW-1];
  assign ser_chan  = fq.rdata[DW +: 3];
  assign ser_data  = fq.rdata[DW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_start_a;
    @(posedge clk) disable iff (srst)
    push && state_r == ARSR_PIN_A && cnt_r == 3'h0 |-> fq.wdata[DW +: 3] == {start_r[1:0], 1'b0};
  endproperty
  a_start_a: assert property (p_start_a) else $error("Pin A first channel wrong");

  property p_start_b_rst;
    @(posedge clk) srst ##1 !srst |-> start_r[3:2] == 2'b01 && start_r[1:0] == 2'b00;
  endproperty
  a_start_b_rst: assert property (p_start_b_rst) else $error("Start fields reset wrong");

  property p_order;
    @(posedge clk) disable iff (srst)
    push && cnt_r != last_cnt |=> fq.wdata[DW +: 3] == $past(fq.wdata[DW +: 3]) + 3'h1;
  endproperty
  a_order: assert property (p_order) else $error("Channels out of order");

  property p_pin_switch;
    @(posedge clk) disable iff (srst)
    push && state_r == ARSR_PIN_A && cnt_r == last_cnt |=> state_r == ARSR_PIN_B && cnt_r == 3'h0;
  endproperty
  a_pin_switch: assert property (p_pin_switch) else $error("Pin B did not follow");

  property p_conv0_adc;
    @(posedge clk) disable iff (srst)
    ce && sample_strobe && src_lo_r[3:2] == 2'b01
      |=> conv_data[0] == $past(adc_data[src_lo_r[1:0]]) && conv_valid[0];
  endproperty
  a_conv0_adc: assert property (p_conv0_adc) else $error("Converter 0 ADC route wrong");

  property p_src_rst;
    @(posedge clk) srst ##1 !srst |-> src_lo_r == 8'h10 && src_hi_r == 8'h32;
  endproperty
  a_src_rst: assert property (p_src_rst) else $error("Source registers reset wrong");

  property p_conv3_rsv;
    @(posedge clk) disable iff (srst)
    ce && sample_strobe && src_hi_r[7:6] == 2'b00 |=> !conv_valid[3] && conv_data[3] == '0;
  endproperty
  a_conv3_rsv: assert property (p_conv3_rsv) else $error("Reserved code routed data");

  property p_conv2_ser;
    @(posedge clk) disable iff (srst)
    ce && sample_strobe && src_hi_r[3]
      |=> conv_data[2] == $past(serial_in_data[src_hi_r[2:0]]);
  endproperty
  a_conv2_ser: assert property (p_conv2_ser) else $error("Converter 2 serial route wrong");

  property p_rsv_rw;
    @(posedge clk) disable iff (srst)
    ce && reg_wr && reg_addr == 8'h17 ##1 ce && reg_rd && reg_addr == 8'h17
      |=> reg_rdata[7:4] == $past(reg_wdata[7:4], 2);
  endproperty
  a_rsv_rw: assert property (p_rsv_rw) else $error("Reserved bits not read back");

  c_pin_b: cover property (@(posedge clk) push && state_r == ARSR_PIN_B);
  c_full:  cover property (@(posedge clk) fq.wvalid && !fq.wready);
  c_rsv:   cover property (@(posedge clk) sample_strobe && !src_ok(src[0]));
endmodule : arsr_top

// File: tb/arsr_top_tb_top.sv
// Self-checking bench for the audio route select bank
`timescale 1ns/1ns
`define CHK(got, exp) check_val(32'(got), 32'(exp))
module arsr_top_tb_top;
  import arsr_pkg::*;
  localparam int DW = 24;
  logic          clk = 1'b0;
  logic          srst = 1'b1;
  logic          ce = 1'b1;
  logic [7:0]    reg_addr = 8'h00;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic [7:0]    reg_wdata = 8'h00;
  logic [7:0]    reg_rdata;
  logic          reg_rvalid;
  logic          sample_strobe = 1'b0;
  logic [DW-1:0] adc_data [4];
  logic [DW-1:0] serial_in_data [8];
  logic [DW-1:0] conv_data [4];
  logic [3:0]    conv_valid;
  logic          serial_format_select = 1'b0;
  logic          frame_strobe = 1'b0;
  logic [DW-1:0] slot_data [8];
  logic          frame_busy;
  logic          ser_valid;
  logic          ser_ready = 1'b0;
  logic          ser_pin_b;
  arsr_chan_type ser_chan;
  logic [DW-1:0] ser_data;
  int            error_cnt = 0;
  int            checks = 0;
  int            seed = 32'h536b;

  always #10 clk = ~clk;

  arsr_top #(.DW(DW), .DEPTH(16)) u_arsr_top (
    .clk(clk), .srst(srst), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sample_strobe(sample_strobe), .adc_data(adc_data), .serial_in_data(serial_in_data),
    .conv_data(conv_data), .conv_valid(conv_valid),
    .serial_format_select(serial_format_select), .frame_strobe(frame_strobe),
    .slot_data(slot_data), .frame_busy(frame_busy),
    .ser_valid(ser_valid), .ser_ready(ser_ready), .ser_pin_b(ser_pin_b),
    .ser_chan(ser_chan), .ser_data(ser_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // Called at a falling edge; strobes last one cycle, then one idle cycle
  // so that back-to-back calls never touch a strobe twice in one step
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    for (int i = 0; i < 3 && reg_rvalid !== 1'b1; i++) @(negedge clk);
    `CHK(reg_rvalid, 1'b1);
    d = reg_rdata;
    @(negedge clk);
  endtask : reg_read

  // Returns {valid, data}; reserved codes give nothing
  function automatic logic [DW:0] route_exp(input logic [3:0] code);
    if (code[3]) return {1'b1, serial_in_data[code[2:0]]};
    if (code[2]) return {1'b1, adc_data[code[1:0]]};
    return '0;
  endfunction : route_exp

  function automatic logic [2:0] chan_exp(input logic [1:0] st, input int i);
    return 3'(st * 2 + i);
  endfunction : chan_exp

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] rd;
    logic [7:0] v [3];
    logic [3:0] c;
    logic [1:0] sa;
    logic [1:0] sb;
    int         n;
    int         got;
    for (int i = 0; i < 8; i++) begin
      slot_data[i]      = '0;
      serial_in_data[i] = '0;
    end
    for (int i = 0; i < 4; i++) adc_data[i] = '0;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    reg_read(8'h17, rd);
    `CHK(rd[1:0], 2'h0);
    `CHK(rd[3:2], 2'h1);
    `CHK(rd[7:4], 4'h0);
    reg_read(8'h18, rd);
    `CHK(rd[3:0], 4'h0);
    `CHK(rd[7:4], 4'h1);
    reg_read(8'h19, rd);
    `CHK(rd, 8'h32);
    // Every bit writable, reserved ones too; unmapped offsets stay silent
    for (int k = 0; k < 4; k++) begin
      for (int a = 0; a < 3; a++) begin
        v[a] = 8'($random(seed));
        reg_write(8'h17 + 8'(a), v[a]);
      end
      reg_write(8'h1a, 8'hff);
      for (int a = 0; a < 3; a++) begin
        reg_read(8'h17 + 8'(a), rd);
        `CHK(rd, v[a]);
      end
      reg_read(8'h1a, rd);
      `CHK(rd, 8'h00);
      // Write then read in the very next cycle: reserved bits come straight back
      reg_addr  = 8'h17;
      reg_wdata = v[1];
      reg_wr    = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      `CHK(reg_rvalid, 1'b1);
      `CHK(reg_rdata, v[1]);
      @(negedge clk);
    end
    // Sweep all sixteen codes, then random ones, across all four channels
    for (int k = 0; k < 24; k++) begin
      c = (k < 16) ? 4'(k) : 4'($random(seed));
      reg_write(8'h18, {c + 4'h1, c});
      reg_write(8'h19, {c + 4'h3, c + 4'h2});
      for (int i = 0; i < 4; i++) adc_data[i] = DW'($random(seed));
      for (int i = 0; i < 8; i++) serial_in_data[i] = DW'($random(seed));
      sample_strobe = 1'b1;
      @(negedge clk);
      sample_strobe = 1'b0;
      `CHK({conv_valid[0], conv_data[0]}, route_exp(c));
      `CHK({conv_valid[1], conv_data[1]}, route_exp(c + 4'h1));
      `CHK({conv_valid[2], conv_data[2]}, route_exp(c + 4'h2));
      `CHK({conv_valid[3], conv_data[3]}, route_exp(c + 4'h3));
    end
    // Frames over every start code and both formats, with stalls and frozen cycles
    for (int f = 0; f < 8; f++) begin
      sa = 2'(f);
      sb = ~sa;
      reg_write(8'h17, {4'h0, sb, sa});
      serial_format_select = f[2];
      n = f[2] ? 4 : 2;
      for (int i = 0; i < 8; i++) slot_data[i] = DW'($random(seed));
      frame_strobe = 1'b1;
      @(negedge clk);
      `CHK(frame_busy, 1'b1);
      // Strobe held a second cycle: a start while busy must be ignored
      @(negedge clk);
      frame_strobe = 1'b0;
      got = 0;
      for (int t = 0; t < 300 && got < 2 * n; t++) begin
        ce        = ($random(seed) & 7) != 0;
        ser_ready = ($random(seed) & 3) != 0;
        if (ce && ser_ready && ser_valid === 1'b1) begin
          `CHK(ser_pin_b, got >= n);
          `CHK(ser_chan, chan_exp(got >= n ? sb : sa, got % n));
          `CHK(ser_data, slot_data[chan_exp(got >= n ? sb : sa, got % n)]);
          got++;
        end
        @(negedge clk);
      end
      `CHK(got, 2 * n);
      ce        = 1'b1;
      ser_ready = 1'b1;
      repeat (4) @(negedge clk);
      `CHK(ser_valid, 1'b0);
      `CHK(frame_busy, 1'b0);
    end
    // Reset in mid-run brings the three control registers and the valid and busy outputs back to their start values
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    `CHK(conv_valid, 4'h0);
    `CHK(ser_valid, 1'b0);
    `CHK(frame_busy, 1'b0);
    reg_read(8'h17, rd);
    `CHK(rd, 8'h04);
    reg_read(8'h18, rd);
    `CHK(rd, 8'h10);
    reg_read(8'h19, rd);
    `CHK(rd, 8'h32);
    finish_test();
  end

  // Whole run needs a few hundred cycles; this leaves ample margin
  initial begin
    #(20 * 20000);
    error_cnt++;
    finish_test();
  end
endmodule : arsr_top_tb_top
